// ---- dv/charge_pump_model.sv ----
// Purpose: charge pump event source for the PLL logic
// Assumes: events only while run is high
// Notes: one-cycle pulse every PERIOD cycles
`timescale 1ns/100ps
module charge_pump_model
#(
	parameter PERIOD = 5
)
(
	input wire sys_clk,
	input wire arst_n,
	input wire run,
	output reg chargePumpEvent
);
// ==========
// event pacing
integer count;
always @(posedge sys_clk or negedge arst_n)
	if (!arst_n)
	begin
		count <= 0;
		chargePumpEvent <= 1'h0;
	end
	else
	begin
		count <= (run && count < PERIOD - 1) ? count + 1 : 0;
		chargePumpEvent <= run && count == PERIOD - 1;
	end
endmodule // charge_pump_model

// ---- dv/clkdist_pwr_properties.sv ----
// Purpose: port checks for reset and power control
// Assumes: bound to clkdist_pwr_ctrl, one clock
// Notes: all checks off while arst_n low
`timescale 1ns/100ps
module clkdist_pwr_properties
#(
	parameter NUM_ECL = 4,
	parameter NUM_LV = 4
)
(
	input wire sys_clk,
	input wire arst_n,
	input wire sleep_pin_n,
	input wire psel,
	input wire penable,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire pllPowerDown,
	input wire dividersOff,
	input wire outSync,
	input wire [2*NUM_ECL-1:0] eclPdMode,
	input wire [NUM_LV-1:0] lvdsOn,
	input wire [NUM_LV-1:0] cmosAOn,
	input wire [NUM_LV-1:0] cmosBOn
);
// ==========
// sequences
default clocking @(posedge sys_clk); endclocking
default disable iff (!arst_n);
sequence setup_s;
	psel && !penable;
endsequence
sequence sleep_s;
	!sleep_pin_n [*5];
endsequence
sequence por_s;
	outSync [*6] ##[1:4] !outSync;
endsequence
// ==========
// properties
apb_one_wait_a: assert property (setup_s |=> pready)
	else $error("no ready after setup");
ready_in_access_a: assert property (pready |-> psel && penable)
	else $error("ready outside access");
err_zero_data_a: assert property (pready && pslverr |-> prdata == 32'h0)
	else $error("error read not zero");
sleep_off_a: assert property (sleep_s |-> dividersOff && pllPowerDown && lvdsOn == '0 && cmosAOn == '0
	&& eclPdMode == {NUM_ECL{2'h2}}) else $error("sleep state wrong");
por_sync_a: assert property ($rose(arst_n) |-> por_s)
	else $error("power-on sync wrong");
wake_sync_a: assert property ($rose(sleep_pin_n) |-> ##[1:6] outSync)
	else $error("no sync after wake");
cmos_b_gate_a: assert property ((cmosBOn & ~cmosAOn) == '0)
	else $error("output B without A");
lv_exclusive_a: assert property ((lvdsOn & cmosAOn) == '0)
	else $error("LVDS and CMOS both on");
endmodule // clkdist_pwr_properties
bind clkdist_pwr_ctrl clkdist_pwr_properties #(.NUM_ECL(NUM_ECL), .NUM_LV(NUM_LV)) u_clkdist_pwr_properties
	(.sys_clk(sys_clk), .arst_n(arst_n), .sleep_pin_n(sleep_pin_n), .psel(psel), .penable(penable), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .pllPowerDown(pllPowerDown), .dividersOff(dividersOff), .outSync(outSync),
	.eclPdMode(eclPdMode), .lvdsOn(lvdsOn), .cmosAOn(cmosAOn), .cmosBOn(cmosBOn));

// ---- dv/tb_top.sv ----
// Purpose: self-checking bench for clkdist_pwr_ctrl
// Assumes: bench is APB master and pin driver
// Notes: every wait bounded
`timescale 1ns/100ps
`include "clkdist_pwr_regs.vh"
module tb_top;
logic sys_clk, arst_n, sleep_pin_n, psel, penable, pwrite, pumpRun, chargePumpEvent, pready, pslverr, rerr;
logic pllPowerDown, oscillatorOff, clkBufOff, refOneBufOff, refTwoBufOff, dividersOff, distBiasOff, outSync;
logic [13:0] paddr;
logic [31:0] pwdata, prdata, rdata;
logic [7:0] eclPdMode, eclSwing;
logic [3:0] eclInvert, lvdsOn, cmosAOn, cmosBOn;
logic [11:0] lvPolarity;
integer n_errors, comparisons, i;
// ==========
// design and far side
clkdist_pwr_ctrl u_clkdist_pwr_ctrl (.sys_clk, .arst_n, .sleep_pin_n, .chargePumpEvent, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pllPowerDown, .oscillatorOff, .clkBufOff,
	.refOneBufOff, .refTwoBufOff, .dividersOff, .distBiasOff, .outSync, .eclPdMode, .eclSwing, .eclInvert,
	.lvdsOn, .cmosAOn, .cmosBOn, .lvPolarity);
charge_pump_model u_charge_pump_model (.sys_clk, .arst_n, .run(pumpRun), .chargePumpEvent);
initial
begin
	sys_clk = 1'h0;
	forever #10 sys_clk = ~sys_clk;
end
// ==========
// shared tasks
task complete_run;
begin
	$display("errors %0d comparisons %0d", n_errors, comparisons);
	if (n_errors == 0 && comparisons > 0)
		$display("Simulation passed");
	else
		$display("Simulation failed");
	$finish;
end
endtask
task chkv(input string name, input logic [7:0] e, input logic [7:0] g);
begin
	comparisons = comparisons + 1;
	if (g !== e)
	begin
		n_errors = n_errors + 1;
		$display("BAD %s exp %h got %h", name, e, g);
	end
end
endtask
task chkb(input string name, input logic e, input logic g);
	chkv(name, {7'h0, e}, {7'h0, g});
endtask
task apb(input logic w, input logic [11:0] idx, input logic [31:0] d);
begin
	@(posedge sys_clk);
	psel <= 1'h1;
	pwrite <= w;
	paddr <= `ADDR_OF(idx);
	pwdata <= d;
	@(posedge sys_clk);
	penable <= 1'h1;
	i = 0;
	do
	begin
		@(posedge sys_clk);
		i = i + 1;
	end
	while (pready !== 1'h1 && i < 20);
	rdata = prdata;
	rerr = pslverr;
	psel <= 1'h0;
	penable <= 1'h0;
	if (pready !== 1'h1)
	begin
		n_errors = n_errors + 1;
		complete_run;
	end
end
endtask
task upd;
begin
	apb(1'h1, `IDX_UPDATE, 32'h1);
	repeat (4) @(posedge sys_clk);
end
endtask
task wait_sync;
begin
	i = 0;
	do
	begin
		@(posedge sys_clk);
		i = i + 1;
	end
	while (outSync !== 1'h1 && i < 30);
	if (outSync !== 1'h1)
	begin
		n_errors = n_errors + 1;
		complete_run;
	end
	else
	begin
		chkb("outSync", 1'h1, outSync);
		i = 0;
		while (outSync === 1'h1 && i < `SYNC_CYCLES)
		begin
			@(posedge sys_clk);
			i = i + 1;
		end
		chkb("syncEnd", 1'h0, outSync);
		repeat (2) @(posedge sys_clk);
	end
end
endtask
task pll(input logic [1:0] m, input logic e);
begin
	apb(1'h1, `IDX_PLLCFG, {30'h0, m});
	upd;
	chkb("pllPowerDown", e, pllPowerDown);
end
endtask
// ==========
// scenarios
task t_regs;
begin
	apb(1'h0, `IDX_PLLCFG, 32'h0);
	chkv("pllcfg", `PLLCFG_RST, rdata[7:0]);
	apb(1'h0, 12'h3FF, 32'h0);
	chkb("pslverr", 1'h1, rerr);
	apb(1'h1, `IDX_ECLBASE + 12'h1, 32'h17);
	chkv("swing1", 8'h2, {6'h0, eclSwing[3:2]});
	upd;
	chkv("swing1", 8'h1, {6'h0, eclSwing[3:2]});
	chkb("invert1", 1'h1, eclInvert[1]);
	chkv("pdmode1", 8'h3, {6'h0, eclPdMode[3:2]});
end
endtask
task t_pll;
begin
	pll(`PLL_NORMAL, 1'h0);
	pll(`PLL_ASYNC_PD, 1'h1);
	pll(`PLL_NORMAL, 1'h0);
	pll(`PLL_SYNC_PD, 1'h0);
	pumpRun <= 1'h1;
	repeat (12) @(posedge sys_clk);
	chkb("syncPd", 1'h1, pllPowerDown);
	pumpRun <= 1'h0;
end
endtask
task t_outs;
begin
	apb(1'h1, `IDX_LVDSBASE, 32'hA6);
	apb(1'h1, `IDX_INBUF, 32'h2);
	upd;
	chkv("lvMode", 8'h3, {5'h0, lvdsOn[0], cmosAOn[0], cmosBOn[0]});
	chkv("lvPol", 8'h5, {5'h0, lvPolarity[2:0]});
	chkv("bufs", 8'h2, {5'h0, refTwoBufOff, refOneBufOff, clkBufOff});
	apb(1'h1, `IDX_LVDSBASE, 32'hA7);
	apb(1'h1, `IDX_DISTCFG, 32'h2);
	upd;
	chkv("lvMode", 8'h0, {5'h0, lvdsOn[0], cmosAOn[0], cmosBOn[0]});
	chkb("distBiasOff", 1'h1, distBiasOff);
	apb(1'h1, `IDX_DISTCFG, 32'h0);
	upd;
	wait_sync;
end
endtask
task t_soft;
begin
	apb(1'h1, `IDX_PORTCFG, 32'h3C);
	repeat (4) @(posedge sys_clk);
	chkv("swing1", 8'h2, {6'h0, eclSwing[3:2]});
	apb(1'h0, `IDX_ECLBASE + 12'h1, 32'h0);
	chkv("ecl1", `ECL_RST, rdata[7:0]);
	apb(1'h1, `IDX_PORTCFG, 32'h18);
	wait_sync;
	apb(1'h0, `IDX_STATUS, 32'h0);
	chkb("softSeen", 1'h1, rdata[4]);
end
endtask
task t_sleep;
begin
	sleep_pin_n <= 1'h0;
	repeat (5) @(posedge sys_clk);
	chkv("sleepOff", 8'h7, {5'h0, dividersOff, oscillatorOff, clkBufOff});
	apb(1'h1, `IDX_ECLBASE + 12'h2, 32'hC);
	upd;
	chkv("eclPdMode", 8'hAA, eclPdMode);
	sleep_pin_n <= 1'h1;
	wait_sync;
	chkv("swing2", 8'h3, {6'h0, eclSwing[5:4]});
	chkv("wakeOn", 8'h0, {5'h0, dividersOff, oscillatorOff, clkBufOff});
	apb(1'h1, `IDX_DISTCFG, 32'h1);
	upd;
	apb(1'h1, `IDX_DISTCFG, 32'h0);
	upd;
	wait_sync;
end
endtask
task t_hard;
begin
	arst_n <= 1'h0;
	@(posedge sys_clk);
	arst_n <= 1'h1;
	wait_sync;
	chkv("swing2", 8'h2, {6'h0, eclSwing[5:4]});
end
endtask
initial
begin
	n_errors = 0;
	comparisons = 0;
	arst_n = 1'h0;
	sleep_pin_n = 1'h1;
	psel = 1'h0;
	penable = 1'h0;
	pwrite = 1'h0;
	paddr = 14'h0;
	pwdata = 32'h0;
	pumpRun = 1'h0;
	repeat (20) @(posedge sys_clk);
	arst_n <= 1'h1;
	wait_sync;
	t_regs;
	t_pll;
	t_outs;
	t_soft;
	t_sleep;
	t_hard;
	complete_run;
end
endmodule // tb_top

// ---- logic/apb_slave_port.v ----
// Purpose: APB slave framing, one-cycle access, error on unmapped
// Assumes: decode supplied by parent
// Notes: pready high in every access phase
`timescale 1ns/100ps
module apb_slave_port
(
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire addrHit,
	output wire wrStrobe,
	output wire rdStrobe,
	output wire slvErr
);
// ==========================================================
// access phase strobes
assign wrStrobe = psel & penable & pwrite & addrHit;
assign rdStrobe = psel & penable & ~pwrite & addrHit;
assign slvErr = psel & penable & ~addrHit;
endmodule // apb_slave_port

// ---- logic/clkdist_pwr_ctrl.v ----
// Purpose: reset, sleep and power-down control with output settings
// Assumes: APB registers, 50 MHz sys_clk, pins synchronous unless async reset
// Notes: shadow registers move to active ones on update strobe
`timescale 1ns/100ps
`include "clkdist_pwr_regs.vh"

module clkdist_pwr_ctrl
#(
	parameter NUM_ECL = 4,
	parameter NUM_LV = 4
)
(
	input wire sys_clk,
	input wire arst_n,
	input wire sleep_pin_n,
	input wire chargePumpEvent,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [13:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	output reg pllPowerDown,
	output reg oscillatorOff,
	output reg clkBufOff,
	output reg refOneBufOff,
	output reg refTwoBufOff,
	output reg dividersOff,
	output reg distBiasOff,
	output reg outSync,
	output reg [2*NUM_ECL-1:0] eclPdMode,
	output reg [2*NUM_ECL-1:0] eclSwing,
	output reg [NUM_ECL-1:0] eclInvert,
	output reg [NUM_LV-1:0] lvdsOn,
	output reg [NUM_LV-1:0] cmosAOn,
	output reg [NUM_LV-1:0] cmosBOn,
	output reg [3*NUM_LV-1:0] lvPolarity
);

// ==========================================================
// declarations
wire sleepSync;
wire [11:0] regIdx;
wire addrHit;
wire wrStrobe;
wire rdStrobe;
wire slvErr;
wire softResetNow;
wire intRstN;
reg [7:0] portCfg;
reg [7:0] shPll;
reg [7:0] shDist;
reg [7:0] shIn;
reg [7:0] shEcl [0:NUM_ECL-1];
reg [7:0] shLv [0:NUM_LV-1];
reg [7:0] acPll;
reg [7:0] acDist;
reg [7:0] acIn;
reg [7:0] acEcl [0:NUM_ECL-1];
reg [7:0] acLv [0:NUM_LV-1];
reg updatePending;
reg pllPdArmed;
reg softRstDone;
reg prevSoftRst;
reg prevDistPd;
reg prevSleep;
reg prevSoftSync;
reg [3:0] syncCount;
reg [31:0] next_prdata;
integer k;
integer m;

// ==========================================================
// pins and bus framing
// sleep pin synchroniser
level_sync u_sleep
(
	.sys_clk(sys_clk),
	.arst_n(arst_n),
	.din(sleep_pin_n),
	.dout(sleepSync)
);

assign regIdx = paddr[13:2];
assign addrHit = (paddr[1:0] == 2'b00) &&
	((regIdx == `IDX_PORTCFG) || (regIdx == `IDX_PLLCFG) || (regIdx == `IDX_INBUF) ||
	(regIdx == `IDX_DISTCFG) || (regIdx == `IDX_UPDATE) || (regIdx == `IDX_STATUS) ||
	((regIdx >= `IDX_ECLBASE) && (regIdx < `IDX_ECLBASE + NUM_ECL)) ||
	((regIdx >= `IDX_LVDSBASE) && (regIdx < `IDX_LVDSBASE + NUM_LV)));

apb_slave_port u_apb
(
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.addrHit(addrHit),
	.wrStrobe(wrStrobe),
	.rdStrobe(rdStrobe),
	.slvErr(slvErr)
);

assign softResetNow = portCfg[`SOFTRST_LO] & portCfg[`SOFTRST_HI];
assign intRstN = arst_n;

// ==========================================================
// register port, live in sleep too
// writes accepted in sleep
always @(posedge sys_clk or negedge intRstN)
begin
	if (!intRstN)
	begin
		portCfg <= `PORTCFG_RST;
		shPll <= `PLLCFG_RST;
		shDist <= `DIST_RST;
		shIn <= `INBUF_RST;
		updatePending <= 1'b0;
		for (k = 0; k < NUM_ECL; k = k + 1)
			shEcl[k] <= `ECL_RST;
		for (k = 0; k < NUM_LV; k = k + 1)
			shLv[k] <= `LVDS_RST;
	end
	else
	begin
		updatePending <= 1'b0;
		if (wrStrobe && regIdx == `IDX_PORTCFG)
			portCfg <= pwdata[7:0];
		if (softResetNow)
		begin
			shPll <= `PLLCFG_RST;
			shDist <= `DIST_RST;
			shIn <= `INBUF_RST;
			for (k = 0; k < NUM_ECL; k = k + 1)
				shEcl[k] <= `ECL_RST;
			for (k = 0; k < NUM_LV; k = k + 1)
				shLv[k] <= `LVDS_RST;
		end
		else if (wrStrobe)
		begin
			if (regIdx == `IDX_PLLCFG)
				shPll <= pwdata[7:0];
			if (regIdx == `IDX_DISTCFG)
				shDist <= pwdata[7:0];
			if (regIdx == `IDX_INBUF)
				shIn <= pwdata[7:0];
			if (regIdx == `IDX_UPDATE)
				updatePending <= pwdata[`UPDATE_BIT];
			for (k = 0; k < NUM_ECL; k = k + 1)
				if (regIdx == `IDX_ECLBASE + k)
					shEcl[k] <= pwdata[7:0];
			for (k = 0; k < NUM_LV; k = k + 1)
				if (regIdx == `IDX_LVDSBASE + k)
					shLv[k] <= pwdata[7:0];
		end
	end
end

// ==========================================================
// active registers
always @(posedge sys_clk or negedge intRstN)
begin
	if (!intRstN)
	begin
		acPll <= `PLLCFG_RST;
		acDist <= `DIST_RST;
		acIn <= `INBUF_RST;
		for (k = 0; k < NUM_ECL; k = k + 1)
			acEcl[k] <= `ECL_RST;
		for (k = 0; k < NUM_LV; k = k + 1)
			acLv[k] <= `LVDS_RST;
	end
	else if (softResetNow)
	begin
		acPll <= `PLLCFG_RST;
		acDist <= `DIST_RST;
		acIn <= `INBUF_RST;
		for (k = 0; k < NUM_ECL; k = k + 1)
			acEcl[k] <= `ECL_RST;
		for (k = 0; k < NUM_LV; k = k + 1)
			acLv[k] <= `LVDS_RST;
	end
	else if (updatePending)
	begin
		acPll <= shPll;
		acDist <= shDist;
		acIn <= shIn;
		for (k = 0; k < NUM_ECL; k = k + 1)
			acEcl[k] <= shEcl[k];
		for (k = 0; k < NUM_LV; k = k + 1)
			acLv[k] <= shLv[k];
	end
end

// ==========================================================
// pll mode, sync sequencing
always @(posedge sys_clk or negedge intRstN)
begin
	if (!intRstN)
	begin
		pllPdArmed <= 1'b0;
		pllPowerDown <= 1'b0;
		prevSoftRst <= 1'b0;
		prevDistPd <= 1'b0;
		prevSleep <= 1'b1;
		prevSoftSync <= 1'b0;
		softRstDone <= 1'b0;
		syncCount <= `SYNC_CYCLES;
		outSync <= 1'b1;
	end
	else
	begin
		prevSoftRst <= softResetNow;
		prevDistPd <= acDist[`DISTPD_BIT];
		prevSleep <= sleepSync;
		prevSoftSync <= acDist[`SOFTSYNC_BIT];
		if (softResetNow)
			softRstDone <= 1'b1;
		case (acPll[1:0])
			`PLL_NORMAL:
			begin
				pllPdArmed <= 1'b0;
				pllPowerDown <= ~sleepSync;
			end
			`PLL_ASYNC_PD:
			begin
				pllPdArmed <= 1'b0;
				pllPowerDown <= 1'b1;
			end
			`PLL_SYNC_PD:
			begin
				if (chargePumpEvent || pllPdArmed)
					pllPdArmed <= 1'b1;
				pllPowerDown <= chargePumpEvent | pllPdArmed | ~sleepSync;
			end
			default:
			begin
				pllPdArmed <= 1'b0;
				pllPowerDown <= ~sleepSync;
			end
		endcase
		// sync on release of soft reset, dist power-down or soft sync, or on sleep exit
		if ((prevSoftRst && !softResetNow) || (prevDistPd && !acDist[`DISTPD_BIT]) ||
			(!prevSleep && sleepSync) || (prevSoftSync && !acDist[`SOFTSYNC_BIT]))
		begin
			syncCount <= `SYNC_CYCLES;
			outSync <= 1'b1;
		end
		else if (syncCount != 4'h0)
		begin
			syncCount <= syncCount - 4'h1;
			outSync <= (syncCount != 4'h1);
		end
		else
			outSync <= 1'b0;
	end
end

// ==========================================================
// outputs and power controls
genvar g;
generate
	for (g = 0; g < NUM_ECL; g = g + 1)
	begin : g_ecl
		always @(posedge sys_clk or negedge intRstN)
		begin
			if (!intRstN)
			begin
				eclPdMode[2*g+1:2*g] <= `ECL_NORMAL;
				eclSwing[2*g+1:2*g] <= 2'h2;
				eclInvert[g] <= 1'b0;
			end
			else
			begin
				eclPdMode[2*g+1:2*g] <= (!sleepSync) ? `ECL_SAFE_PD : acEcl[g][`ECL_PD_LSB+1:`ECL_PD_LSB];
				eclSwing[2*g+1:2*g] <= acEcl[g][`ECL_SWING_LSB+1:`ECL_SWING_LSB];
				eclInvert[g] <= acEcl[g][`ECL_POL_BIT];
			end
		end
	end
	for (g = 0; g < NUM_LV; g = g + 1)
	begin : g_lv
		always @(posedge sys_clk or negedge intRstN)
		begin
			if (!intRstN)
			begin
				lvdsOn[g] <= 1'b0;
				cmosAOn[g] <= 1'b0;
				cmosBOn[g] <= 1'b0;
				lvPolarity[3*g+2:3*g] <= 3'h0;
			end
			else
			begin
				lvdsOn[g] <= sleepSync & ~acLv[g][`LV_PD_BIT] & ~acLv[g][`LV_CMOS_BIT];
				cmosAOn[g] <= sleepSync & ~acLv[g][`LV_PD_BIT] & acLv[g][`LV_CMOS_BIT];
				cmosBOn[g] <= sleepSync & ~acLv[g][`LV_PD_BIT] & acLv[g][`LV_CMOS_BIT] &
					acLv[g][`LV_BEN_BIT];
				lvPolarity[3*g+2:3*g] <= acLv[g][`LV_POL_LSB+2:`LV_POL_LSB];
			end
		end
	end
endgenerate

always @(posedge sys_clk or negedge intRstN)
begin
	if (!intRstN)
	begin
		oscillatorOff <= 1'b0;
		clkBufOff <= 1'b0;
		refOneBufOff <= 1'b0;
		refTwoBufOff <= 1'b0;
		dividersOff <= 1'b0;
		distBiasOff <= 1'b0;
		pready <= 1'b0;
		pslverr <= 1'b0;
		prdata <= 32'h00000000;
	end
	else
	begin
		oscillatorOff <= ~sleepSync;
		dividersOff <= ~sleepSync | acDist[`DISTPD_BIT];
		clkBufOff <= ~sleepSync | acIn[`IN_CLK_BIT];
		refOneBufOff <= acIn[`IN_REFERENCE_INPUT_ONE_BIT];
		refTwoBufOff <= acIn[`IN_REFERENCE_INPUT_TWO_BIT];
		distBiasOff <= acDist[`DISTPD_BIT];
		pready <= psel & ~penable;
		pslverr <= psel & ~penable & ~addrHit;
		if (rdStrobe || slvErr)
			prdata <= 32'h00000000;
		else if (psel && !penable)
			prdata <= addrHit ? next_prdata : 32'h00000000;
	end
end

// ==========================================================
// read mux, shadow view
always @*
begin
	next_prdata = 32'h00000000;
	if (regIdx == `IDX_PORTCFG)
		next_prdata[7:0] = portCfg;
	if (regIdx == `IDX_PLLCFG)
		next_prdata[7:0] = shPll;
	if (regIdx == `IDX_DISTCFG)
		next_prdata[7:0] = shDist;
	if (regIdx == `IDX_INBUF)
		next_prdata[7:0] = shIn;
	if (regIdx == `IDX_STATUS)
		next_prdata[4:0] = {softRstDone, outSync, pllPowerDown, distBiasOff, ~sleepSync};
	for (m = 0; m < NUM_ECL; m = m + 1)
		if (regIdx == `IDX_ECLBASE + m)
			next_prdata[7:0] = shEcl[m];
	for (m = 0; m < NUM_LV; m = m + 1)
		if (regIdx == `IDX_LVDSBASE + m)
			next_prdata[7:0] = shLv[m];
end
endmodule // clkdist_pwr_ctrl

// ---- logic/clkdist_pwr_regs.vh ----
// Purpose: register offsets, field positions, reset values for reset/power control
// Assumes: APB byte addresses, one register per aligned word
// Notes: printed offsets not all multiples of four, so byte address = 4 * index
`ifndef CLKDIST_PWR_REGS_VH
`define CLKDIST_PWR_REGS_VH

// ==========================================================
// register indices
`define IDX_PORTCFG 12'h000
`define IDX_PLLCFG 12'h010
`define IDX_ECLBASE 12'h0F0
`define IDX_LVDSBASE 12'h140
`define IDX_INBUF 12'h1E0
`define IDX_DISTCFG 12'h230
`define IDX_UPDATE 12'h232
`define IDX_STATUS 12'h240
`define ADDR_OF(i) ({(i), 2'b00})

// ==========================================================
// field positions
`define SOFTRST_LO 2
`define SOFTRST_HI 5
`define UPDATE_BIT 0
`define DISTPD_BIT 1
`define SOFTSYNC_BIT 0
`define ECL_PD_LSB 0
`define ECL_SWING_LSB 2
`define ECL_POL_BIT 4
`define LV_PD_BIT 0
`define LV_CMOS_BIT 1
`define LV_BEN_BIT 2
`define LV_POL_LSB 5
`define IN_CLK_BIT 0
`define IN_REFERENCE_INPUT_ONE_BIT 1
`define IN_REFERENCE_INPUT_TWO_BIT 2

// ==========================================================
// reset values and codes
`define PORTCFG_RST 8'h18
`define PLLCFG_RST 8'h01
`define ECL_RST 8'h08
`define LVDS_RST 8'h00
`define INBUF_RST 8'h00
`define DIST_RST 8'h00
`define PLL_NORMAL 2'h0
`define PLL_ASYNC_PD 2'h1
`define PLL_SYNC_PD 2'h3
`define ECL_NORMAL 2'h0
`define ECL_SAFE_PD 2'h2
`define ECL_TOTAL_PD 2'h3
`define SYNC_CYCLES 4'h8

`endif

// ---- logic/level_sync.v ----
// Purpose: two-flop synchroniser, low level reaches dout after two clocks, asynchronous reset to high
// Assumes: active-low input, reset drives output high (idle level)
// Notes: first flop read only by second
`timescale 1ns/100ps
module level_sync
(
	input wire sys_clk,
	input wire arst_n,
	input wire din,
	output reg dout
);
reg stage1;

// ==========================================================
// two flops
always @(posedge sys_clk or negedge arst_n)
begin
	if (!arst_n)
	begin
		stage1 <= 1'b1;
		dout <= 1'b1;
	end
	else
	begin
		stage1 <= din;
		dout <= stage1;
	end
end
endmodule // level_sync
